// >>> rtl/mspi_pkg.sv
package mspi_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 32;

  // byte offsets of the registers
  localparam logic [7:0] OFS_TEST_A = 8'h00;
  localparam logic [7:0] OFS_TEST_B = 8'h04;
  localparam logic [7:0] OFS_SIZE_LOW = 8'h08;
  localparam logic [7:0] OFS_SIZE_HIGH = 8'h0C;
  localparam logic [7:0] OFS_PAGE = 8'h10;
  localparam logic [7:0] OFS_MISC = 8'h14;
  localparam logic [7:0] OFS_RAM_POS = 8'h18;

  // memory_size_low fields
  localparam int unsigned REG_SW_BIT = 7;
  localparam int unsigned EEP_SW_LSB = 4;
  localparam int unsigned RAM_SW_LSB = 0;

  // memory_size_high fields
  localparam int unsigned FLASH_SW_LSB = 6;
  localparam int unsigned PAG_SW_LSB = 0;

  // misc control fields
  localparam int unsigned ROM_HIGH_HALF_BIT = 1;

  // ram position fields
  localparam int unsigned RAM_POS_LSB = 3;
  localparam int unsigned RAM_HIGH_ALIGN_BIT = 0;

  // reset values
  localparam logic [7:0] RST_RAM_POS = 8'h09;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [5:0] RST_PAGE_ANY = 6'h00;
  localparam logic [5:0] RST_PAGE_SPECIAL = 6'h3C;

  // page index geometry
  localparam int unsigned PAGE_W = 6;
  localparam logic [15:0] WINDOW_LOW = 16'h8000;
  localparam logic [15:0] WINDOW_HIGH = 16'hBFFF;

  // flash allocation codes that can fold into the upper half
  localparam logic [1:0] FLASH_48K = 2'h2;
  localparam logic [1:0] FLASH_64K = 2'h3;

  // first internal page for each paging split code
  localparam logic [5:0] ONCHIP_FIRST_128K = 6'h38;
  localparam logic [5:0] ONCHIP_FIRST_256K = 6'h30;
  localparam logic [5:0] ONCHIP_FIRST_512K = 6'h20;
  localparam logic [5:0] ONCHIP_FIRST_1M = 6'h00;

  typedef enum logic [0:0] {
    MSPI_IDLE = 1'b0,
    MSPI_ACK = 1'b1
  } mspi_bus_e;

endpackage

// >>> rtl/mspi_regs.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps

// Operation
// - test registers readable, writes change nothing
// - size low returns switches, ignores writes
// - bit 7: register space 1K or 2K
// - bits 5:4: eeprom 0K/2K/4K/8K
// - ram code: 2K steps, mappable region per code
// - ram base from position bits per code
// - smaller ram placed inside region by align
// - align 0 lowest, 1 highest in region
// - size high returns switches, ignores writes
// - bits 7:6: flash 0K/16K/48K/64K
// - paging code gives off-chip/on-chip split
// - 48K/64K flash governed by high-half bit
// - high-half set: lower half direct access off
// - index bits 5:0 pick window page
// - index n selects page n of 64
// - index readable; option sets write access, reset
// - bus write to index effective next cycle
// - call/return path reads, writes index directly
module mspi_regs
  import mspi_pkg::*;
#(
  parameter logic REGISTER_SPACE_SWITCH = 1'b0,
  parameter logic [1:0] EEPROM_SPACE_SWITCH = 2'h0,
  parameter logic [2:0] RAM_SPACE_SWITCH = 3'h0,
  parameter logic [1:0] FLASH_SPACE_SWITCH = 2'h0,
  parameter logic [1:0] PAGING_SPLIT_SWITCH = 2'h0,
  parameter logic PAGE_WRITE_ANYTIME = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic coreEn,
  input wire logic specialMode,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic callPageWrite,
  input wire logic [PAGE_W-1:0] callPageData,
  output logic [PAGE_W-1:0] callPageRead,
  output logic [PAGE_W-1:0] pageSelect,
  output logic pageWindowInternal,
  output logic [15:0] ramBaseAddr,
  output logic flashLowHalfEnable
);

  localparam logic [5:0] PAGE_RESET = PAGE_WRITE_ANYTIME ? RST_PAGE_ANY : RST_PAGE_SPECIAL;

  mspi_bus_e busState;
  logic [PAGE_W-1:0] programPageIndex;
  logic [7:0] ramPositionRegister;
  logic romHighHalfOnly;
  logic [7:0] memorySizeLow;
  logic [7:0] memorySizeHigh;
  logic [7:0] readByte;
  logic request;
  logic commit;
  logic writeCommit;
  logic pageWriteAllowed;
  logic [4:0] next_ramBase2k;

  // switch images are constants; nothing on the bus can reach them
  assign memorySizeLow = {REGISTER_SPACE_SWITCH, 1'b0, EEPROM_SPACE_SWITCH,
                          1'b0, RAM_SPACE_SWITCH};
  assign memorySizeHigh = {FLASH_SPACE_SWITCH, 4'h0, PAGING_SPLIT_SWITCH};

  // byte address of a word index
  function automatic logic [7:0] byteAddr(input logic [ADDR_W-1:0] idx);
    byteAddr = {3'h0, idx, 2'b00};
  endfunction

  // mappable region size in 2K units
  function automatic logic [4:0] regionUnits(input logic [2:0] code);
    case (code)
      3'h0: regionUnits = 5'h01;
      3'h1: regionUnits = 5'h02;
      3'h2: regionUnits = 5'h04;
      3'h3: regionUnits = 5'h04;
      default: regionUnits = 5'h08;
    endcase
  endfunction

  // first on-chip page for the paging split
  function automatic logic [5:0] onchipFirst(input logic [1:0] code);
    case (code)
      2'h0: onchipFirst = ONCHIP_FIRST_128K;
      2'h1: onchipFirst = ONCHIP_FIRST_256K;
      2'h2: onchipFirst = ONCHIP_FIRST_512K;
      default: onchipFirst = ONCHIP_FIRST_1M;
    endcase
  endfunction

  assign request = (avs_read || avs_write);
  assign commit = request && (busState == MSPI_ACK);
  assign writeCommit = commit && avs_write && avs_byteenable[0];
  assign pageWriteAllowed = PAGE_WRITE_ANYTIME || specialMode;

  // one wait cycle, then a one-cycle ack with data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busState <= MSPI_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (coreEn) begin
      case (busState)
        MSPI_IDLE: begin
          if (request) begin
            busState <= MSPI_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        MSPI_ACK: begin
          busState <= MSPI_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          busState <= MSPI_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read mux; unmapped and test locations read zero
  always_comb begin
    readByte = 8'h00;
    case (byteAddr(avs_address))
      OFS_TEST_A: readByte = 8'h00;
      OFS_TEST_B: readByte = 8'h00;
      OFS_SIZE_LOW: readByte = memorySizeLow;
      OFS_SIZE_HIGH: readByte = memorySizeHigh;
      OFS_PAGE: readByte = {2'b00, programPageIndex};
      OFS_MISC: readByte = {6'h00, romHighHalfOnly, 1'b0};
      OFS_RAM_POS: readByte = ramPositionRegister;
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (coreEn) begin
      if (request && busState == MSPI_IDLE && avs_read) begin
        avs_readdata <= {24'h000000, readByte};
      end
    end
  end

  // page index; the call/return path wins over a bus write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      programPageIndex <= PAGE_RESET;
    end else if (coreEn) begin
      if (callPageWrite) begin
        programPageIndex <= callPageData;
      end else if (writeCommit && byteAddr(avs_address) == OFS_PAGE && pageWriteAllowed) begin
        programPageIndex <= avs_writedata[PAGE_W-1:0];
      end
    end
  end

  // test and size locations have no write path at all
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      romHighHalfOnly <= RST_MISC[ROM_HIGH_HALF_BIT];
    end else if (coreEn) begin
      if (writeCommit && byteAddr(avs_address) == OFS_MISC) begin
        romHighHalfOnly <= avs_writedata[ROM_HIGH_HALF_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramPositionRegister <= RST_RAM_POS;
    end else if (coreEn) begin
      if (writeCommit && byteAddr(avs_address) == OFS_RAM_POS) begin
        ramPositionRegister <= {avs_writedata[7:RAM_POS_LSB], 2'b00,
                                avs_writedata[RAM_HIGH_ALIGN_BIT]};
      end
    end
  end

  // ram base in 2K units: keep position bits above the region, then align
  always_comb begin
    next_ramBase2k = ramPositionRegister[7:RAM_POS_LSB]
                     & ~(regionUnits(RAM_SPACE_SWITCH) - 5'h01);
    if (ramPositionRegister[RAM_HIGH_ALIGN_BIT]) begin
      next_ramBase2k = next_ramBase2k + regionUnits(RAM_SPACE_SWITCH)
                       - ({2'b00, RAM_SPACE_SWITCH} + 5'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramBaseAddr <= '0;
    end else if (coreEn) begin
      ramBaseAddr <= {next_ramBase2k, 11'h000};
    end
  end

  // lower-half flash only folds away for the two large allocations
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flashLowHalfEnable <= 1'b1;
    end else if (coreEn) begin
      flashLowHalfEnable <= !(romHighHalfOnly && (FLASH_SPACE_SWITCH == FLASH_48K
                              || FLASH_SPACE_SWITCH == FLASH_64K));
    end
  end

  // window page outputs lag the index by one edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pageSelect <= PAGE_RESET;
      pageWindowInternal <= 1'b0;
      callPageRead <= PAGE_RESET;
    end else if (coreEn) begin
      pageSelect <= programPageIndex;
      pageWindowInternal <= (programPageIndex >= onchipFirst(PAGING_SPLIT_SWITCH));
      callPageRead <= programPageIndex;
    end
  end

endmodule

// >>> tb/mspi_cpu_model.sv
`timescale 1ns/100ps
module mspi_cpu_model (
  input wire logic core_clk,
  input wire logic callGo,
  input wire logic [5:0] callValue,
  output logic callPageWrite = 1'b0,
  output logic [5:0] callPageData = 6'h00
);
  // idle data toggles so a stale value never looks valid
  always @(posedge core_clk) begin
    callPageWrite <= callGo;
    callPageData <= callGo ? callValue : ~callPageData;
  end
endmodule

// >>> tb/mspi_regs_checker.sv
`timescale 1ns/100ps
module mspi_regs_checker
  import mspi_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic coreEn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic callPageWrite,
  input wire logic [PAGE_W-1:0] callPageData,
  input wire logic [PAGE_W-1:0] callPageRead,
  input wire logic [PAGE_W-1:0] pageSelect
);
  logic [PAGE_W-1:0] wrPage;
  assign wrPage = avs_writedata[PAGE_W-1:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ack_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest && coreEn |=> !avs_waitrequest)
    else $error("ack late");
  a_ack_single: assert property (!avs_waitrequest && coreEn |=> avs_waitrequest)
    else $error("ack too long");
  a_read_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_holds: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved");
  a_call_path: assert property (
    callPageWrite && coreEn ##1 coreEn |=> callPageRead == $past(callPageData, 2))
    else $error("call write lost");
  // page output lags the index, so a quiet edge shows two edges later
  a_page_quiet: assert property (
    !callPageWrite && !(avs_write && !avs_waitrequest) |-> ##2 $stable(pageSelect))
    else $error("page moved without a write");
  a_bus_page: assert property (
    avs_write && !avs_waitrequest && coreEn && avs_byteenable[0]
    && avs_address == 3'h4 && !callPageWrite ##1 coreEn && !callPageWrite
    |=> pageSelect == $past(wrPage, 2)) else $error("page write lost");
  a_freeze: assert property (
    !coreEn |=> $stable(pageSelect) && $stable(callPageRead))
    else $error("state moved while frozen");
endmodule

bind mspi_regs mspi_regs_checker mspi_regs_checker_inst (.core_clk, .sys_rst, .coreEn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .callPageWrite, .callPageData, .callPageRead, .pageSelect);

// >>> tb/mspi_regs_tb.sv
`timescale 1ns/100ps
module mspi_regs_tb;
  import mspi_pkg::*;
  typedef struct packed {logic [7:0] ofs; logic [7:0] d; logic [7:0] exp;} mspi_row_s;
  logic core_clk = 0, sys_rst = 1, coreEn = 1, specialMode = 0, avs_read = 0, avs_write = 0;
  logic callGo = 0, avs_waitrequest, callPageWrite, pageWindowInternal, flashLowHalfEnable;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [PAGE_W-1:0] callValue = '0, callPageData, callPageRead, pageSelect;
  logic [15:0] ramBaseAddr;
  int err_total = 0, comparisons = 0;
  mspi_row_s rows [8] = '{'{OFS_PAGE, 8'hFF, 8'h3F}, '{OFS_PAGE, 8'h2F, 8'h2F},
    '{OFS_TEST_A, 8'hFF, 8'h00}, '{OFS_TEST_B, 8'h5A, 8'h00}, '{OFS_SIZE_LOW, 8'h00, 8'hA4},
    '{OFS_SIZE_HIGH, 8'h00, 8'hC1}, '{8'h1C, 8'hFF, 8'h00}, '{OFS_RAM_POS, 8'h41, 8'h41}};

  always #20 core_clk = ~core_clk;

  mspi_regs #(.REGISTER_SPACE_SWITCH(1'b1), .EEPROM_SPACE_SWITCH(2'h2),
    .RAM_SPACE_SWITCH(3'h4), .FLASH_SPACE_SWITCH(2'h3), .PAGING_SPLIT_SWITCH(2'h1))
    mspi_regs_inst (.*);
  mspi_cpu_model mspi_cpu_model_inst (.*);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits on the handshake only; the watchdog bounds a hang
  task bus(input logic wr, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= ADDR_W'(ofs >> 2);
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask

  task summarize;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 0;
    repeat (2) @(negedge core_clk);
    chk(pageSelect, 0);
    chk(ramBaseAddr, 16'h1800);
    chk(flashLowHalfEnable, 1);
    foreach (rows[i]) begin
      bus(1, rows[i].ofs, rows[i].d);
      bus(0, rows[i].ofs, 0);
      chk(rd, rows[i].exp);
    end
    chk(ramBaseAddr, 16'h5800);
    bus(1, OFS_RAM_POS, 8'h40);
    repeat (2) @(negedge core_clk);
    chk(ramBaseAddr, 16'h4000);
    chk(pageWindowInternal, 0);
    bus(1, OFS_PAGE, 8'h30);
    @(negedge core_clk);
    chk(pageSelect, 6'h2F);
    repeat (2) @(negedge core_clk);
    chk(pageSelect, 6'h30);
    chk(pageWindowInternal, 1);
    bus(1, OFS_MISC, 8'h02);
    repeat (2) @(negedge core_clk);
    chk(flashLowHalfEnable, 0);
    @(posedge core_clk);
    callGo <= 1;
    callValue <= 6'h3A;
    @(posedge core_clk);
    callGo <= 0;
    repeat (3) @(negedge core_clk);
    chk(callPageRead, 6'h3A);
    chk(pageSelect, 6'h3A);
    @(posedge core_clk);
    coreEn <= 0;
    callGo <= 1;
    callValue <= 6'h05;
    @(posedge core_clk);
    callGo <= 0;
    repeat (3) @(posedge core_clk);
    coreEn <= 1;
    @(negedge core_clk);
    chk(pageSelect, 6'h3A);
    // mid-run reset must bring back index, position and misc defaults
    @(posedge core_clk);
    sys_rst <= 1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    repeat (2) @(negedge core_clk);
    chk(pageSelect, 0);
    chk(ramBaseAddr, 16'h1800);
    chk(flashLowHalfEnable, 1);
    summarize();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    summarize();
  end
endmodule
